/* shbp_pkg.sv */
// constants and types shared by the sram-like host bus port
package shbp_pkg;
  // widths of the host pins and the internal words
  localparam int HOST_DW  = 16;
  localparam int HOST_AW  = 7;
  localparam int WORD_DW  = 32;
  localparam int CSR_AW   = 6;
  localparam int IRQ_SRCS = 8;
  localparam int HOLD_W   = 8;
  localparam int HCNT_W   = 16;

  // halfword address map when the fifo select pin is low (bits [6:4])
  localparam logic [2:0] RX_REGION  = 3'h0;
  localparam logic [2:0] TX_REGION  = 3'h1;

  // values after reset
  localparam logic [15:0] HALF_RST  = 16'h0000;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [HCNT_W-1:0] HCNT_RST = 16'h0000;

  // hold-off tick: one unit of the programmed interval
  localparam int CLK_PERIOD_NS = 4;
  localparam int HOLD_TICK_NS  = 40;
  localparam int HOLD_TICK_CYC = (HOLD_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // sequencer states
  typedef enum logic [1:0] {
    SHBP_IDLE    = 2'b00,
    SHBP_RD_WAIT = 2'b01,
    SHBP_RD_DRV  = 2'b10,
    SHBP_WR_HOLD = 2'b11
  } shbp_state_t;
endpackage

/* shbp_port.sv */
// host bus port: pin synchronisation, decode, 16/32 packing, csr and fifo paths, interrupt line
//
// Contract
// - 16-bit pins packed into 32-bit internal words
// - big-endian mode byte-swaps control register data
// - 7-bit halfword address selects register or fifo
// - data bus driven only during qualified reads
// - low read strobe with chip select reads
// - low write strobe with chip select writes
// - strobes ignored without active chip select
// - qualified write wakes device from reduced power
// - fifo select forces fifo access, ignores upper address
// - static-memory style programmed access to all targets
// - programmable inactive interval after interrupt deasserts
// - control registers on separate internal register bus
module shbp_port (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // host pins (asynchronous)
  input  wire logic [shbp_pkg::HOST_DW-1:0]  host_data_in,
  output logic      [shbp_pkg::HOST_DW-1:0]  host_data_out,
  output logic                               host_data_oe,
  input  wire logic [shbp_pkg::HOST_AW-1:0]  host_addr,
  input  wire logic                          read_strobe_low,
  input  wire logic                          write_strobe_low,
  input  wire logic                          chip_select_low,
  input  wire logic                          fifo_select,
  // configuration
  input  wire logic                          big_endian,
  input  wire logic                          reduced_power,
  // wake request toward power control
  output logic                               wake_request,
  // internal control register bus
  output logic      [shbp_pkg::CSR_AW-1:0]   csr_addr,
  output logic      [shbp_pkg::WORD_DW-1:0]  csr_wdata,
  output logic                               csr_wr,
  output logic                               csr_rd,
  input  wire logic [shbp_pkg::WORD_DW-1:0]  csr_rdata,
  // transmit data path
  output logic      [shbp_pkg::WORD_DW-1:0]  tx_data,
  output logic                               tx_push,
  // receive data path (show-ahead head word)
  input  wire logic [shbp_pkg::WORD_DW-1:0]  rx_data,
  output logic                               rx_pop,
  // interrupt configuration and line
  input  wire logic [shbp_pkg::IRQ_SRCS-1:0] irq_sources,
  input  wire logic [shbp_pkg::IRQ_SRCS-1:0] irq_enable,
  input  wire logic                          irq_active_high,
  input  wire logic                          irq_push_pull,
  input  wire logic [shbp_pkg::HOLD_W-1:0]   irq_holdoff,
  output logic                               irq_out,
  output logic                               irq_oe
);

  // two-stage synchronisers for every host pin
  // packed order, msb first: data, address, read, write, chip select, fifo select
  // every pin shares one two-stage path, so strobes and qualifiers stay aligned
  localparam int SYN_W = shbp_pkg::HOST_DW + shbp_pkg::HOST_AW + 4;
  logic [SYN_W-1:0] syn1_q;       // first stage, read only by syn2_q
  logic [SYN_W-1:0] syn2_q;       // second stage, safe to use

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syn1_q <= {SYN_W{1'b1}};
      syn2_q <= {SYN_W{1'b1}};
    end else begin
      syn1_q <= {host_data_in, host_addr, read_strobe_low, write_strobe_low, chip_select_low, fifo_select};
      syn2_q <= syn1_q;
    end
  end

  // unpack synchronised pins
  wire [shbp_pkg::HOST_DW-1:0] data_s  = syn2_q[SYN_W-1 -: shbp_pkg::HOST_DW];
  wire [shbp_pkg::HOST_AW-1:0] addr_s  = syn2_q[4 +: shbp_pkg::HOST_AW];
  wire                         rd_n_s  = syn2_q[3];
  wire                         wr_n_s  = syn2_q[2];
  wire                         cs_n_s  = syn2_q[1];
  wire                         fsel_s  = syn2_q[0];

  // qualified strobes
  wire rd_act = ~cs_n_s & ~rd_n_s;
  wire wr_act = ~cs_n_s & ~wr_n_s;

  logic rd_prev_q;                 // previous qualified read level
  logic wr_prev_q;                 // previous qualified write level

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  wire rd_go = rd_act & ~rd_prev_q;
  wire wr_go = wr_act & ~wr_prev_q & ~rd_act;

  // address decode of the halfword address
  wire [2:0] region  = addr_s[6:4];
  wire       to_rx   = fsel_s | (region == shbp_pkg::RX_REGION);
  wire       to_tx   = fsel_s | (region == shbp_pkg::TX_REGION);
  // one port reaches register bus, tx fifo and rx fifo alike
  wire       rd_csr  = ~to_rx;
  wire       wr_csr  = ~to_tx;
  wire       half_hi = addr_s[0];
  wire [shbp_pkg::CSR_AW-1:0] word_idx = addr_s[6:1];

  // byte reordering on the control register path only
  function automatic logic [31:0] shbp_swap(input logic [31:0] w, input logic be);
    shbp_swap = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

  // sequencer state and data holders
  shbp_pkg::shbp_state_t st_q, st_d;
  logic [31:0] rword_q, rword_d;           // word being read out
  logic [15:0] wlow_q,  wlow_d;            // low halfword waiting for its pair
  logic        rhalf_q, rhalf_d;           // which half is driven
  logic        whalf_q, whalf_d;           // which half the write targets
  logic        wcsr_q,  wcsr_d;            // write goes to register bus
  logic [shbp_pkg::CSR_AW-1:0] widx_q, widx_d;
  logic [15:0] dout_d;
  logic        doe_d;
  logic        csr_wr_d, csr_rd_d, tx_push_d, rx_pop_d;
  logic [31:0] csr_wdata_d, tx_data_d;
  logic [shbp_pkg::CSR_AW-1:0] csr_addr_d;

  // next-state and output decisions of the sequencer
  always_comb begin
    st_d        = st_q;
    rword_d     = rword_q;
    wlow_d      = wlow_q;
    rhalf_d     = rhalf_q;
    whalf_d     = whalf_q;
    wcsr_d      = wcsr_q;
    widx_d      = widx_q;
    doe_d       = 1'b0;
    dout_d      = host_data_out;
    csr_wr_d    = 1'b0;
    csr_rd_d    = 1'b0;
    tx_push_d   = 1'b0;
    rx_pop_d    = 1'b0;
    csr_addr_d  = csr_addr;
    csr_wdata_d = csr_wdata;
    tx_data_d   = tx_data;
    case (st_q)
      shbp_pkg::SHBP_IDLE: begin
        if (rd_go) begin
          rhalf_d = half_hi;
          if (half_hi) begin
            // upper half comes from the word fetched on the lower half
            st_d     = shbp_pkg::SHBP_RD_DRV;
            rx_pop_d = to_rx;
          end else if (rd_csr) begin
            // fetch over the register bus, data back next cycle
            csr_addr_d = word_idx;
            csr_rd_d   = 1'b1;
            st_d       = shbp_pkg::SHBP_RD_WAIT;
          end else begin
            rword_d = rx_data;
            st_d    = shbp_pkg::SHBP_RD_DRV;
          end
        end else if (wr_go) begin
          whalf_d = half_hi;
          wcsr_d  = wr_csr;
          widx_d  = word_idx;
          st_d    = shbp_pkg::SHBP_WR_HOLD;
        end
      end
      shbp_pkg::SHBP_RD_WAIT: begin
        rword_d = shbp_swap(csr_rdata, big_endian);
        st_d    = shbp_pkg::SHBP_RD_DRV;
      end
      shbp_pkg::SHBP_RD_DRV: begin
        // drive only while the qualified read lasts
        if (rd_act) begin
          doe_d  = 1'b1;
          dout_d = rhalf_q ? rword_q[31:16] : rword_q[15:0];
        end else begin
          st_d = shbp_pkg::SHBP_IDLE;
        end
      end
      shbp_pkg::SHBP_WR_HOLD: begin
        // data is taken when the write strobe releases
        if (!wr_act) begin
          st_d = shbp_pkg::SHBP_IDLE;
          if (!whalf_q) begin
            wlow_d = data_s;
          end else if (wcsr_q) begin
            csr_addr_d  = widx_q;
            csr_wdata_d = shbp_swap({data_s, wlow_q}, big_endian);
            csr_wr_d    = 1'b1;
          end else begin
            tx_data_d = {data_s, wlow_q};
            tx_push_d = 1'b1;
          end
        end
      end
      default: begin
        st_d = shbp_pkg::SHBP_IDLE;
      end
    endcase
  end

  // sequencer registers and all bus-facing outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q          <= shbp_pkg::SHBP_IDLE;
      rword_q       <= shbp_pkg::WORD_RST;
      wlow_q        <= shbp_pkg::HALF_RST;
      rhalf_q       <= 1'b0;
      whalf_q       <= 1'b0;
      wcsr_q        <= 1'b0;
      widx_q        <= '0;
      host_data_out <= shbp_pkg::HALF_RST;
      host_data_oe  <= 1'b0;
      csr_addr      <= '0;
      csr_wdata     <= shbp_pkg::WORD_RST;
      csr_wr        <= 1'b0;
      csr_rd        <= 1'b0;
      tx_data       <= shbp_pkg::WORD_RST;
      tx_push       <= 1'b0;
      rx_pop        <= 1'b0;
    end else begin
      st_q          <= st_d;
      rword_q       <= rword_d;
      wlow_q        <= wlow_d;
      rhalf_q       <= rhalf_d;
      whalf_q       <= whalf_d;
      wcsr_q        <= wcsr_d;
      widx_q        <= widx_d;
      host_data_out <= dout_d;
      host_data_oe  <= doe_d;
      csr_addr      <= csr_addr_d;
      csr_wdata     <= csr_wdata_d;
      csr_wr        <= csr_wr_d;
      csr_rd        <= csr_rd_d;
      tx_data       <= tx_data_d;
      tx_push       <= tx_push_d;
      rx_pop        <= rx_pop_d;
    end
  end

  // wake request on the start of a qualified write in reduced power
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= wr_act & ~wr_prev_q & reduced_power;
    end
  end

  // interrupt request with hold-off after each deassertion
  wire irq_req = |(irq_sources & irq_enable);
  localparam int HCNT_W_L = shbp_pkg::HCNT_W;
  localparam logic [HCNT_W_L-1:0] TICK = HCNT_W_L'(shbp_pkg::HOLD_TICK_CYC);
  // inactive interval in clock cycles, loaded at each deassertion
  wire [HCNT_W_L-1:0] hold_load;
  assign hold_load = HCNT_W_L'(irq_holdoff * TICK);

  logic                irq_act_q, irq_act_d;   // internal asserted state
  logic [HCNT_W_L-1:0] hold_q,    hold_d;      // remaining inactive cycles
  wire                 hold_zero = (hold_q == shbp_pkg::HCNT_RST);

  // hold-off counter and assertion decision
  always_comb begin
    irq_act_d = irq_act_q;
    hold_d    = hold_zero ? hold_q : hold_q - 1'b1;
    if (irq_act_q && !irq_req) begin
      irq_act_d = 1'b0;
      hold_d    = hold_load;
    end else if (!irq_act_q && irq_req && hold_zero) begin
      irq_act_d = 1'b1;
    end
  end

  // pin level and enable from polarity and buffer type
  wire irq_lvl_d = irq_act_d ~^ irq_active_high;
  wire irq_oe_d  = irq_push_pull | irq_act_d;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_act_q <= 1'b0;
      hold_q    <= shbp_pkg::HCNT_RST;
      irq_out   <= 1'b0;
      irq_oe    <= 1'b0;
    end else begin
      irq_act_q <= irq_act_d;
      hold_q    <= hold_d;
      irq_out   <= irq_push_pull ? irq_lvl_d : 1'b0;
      irq_oe    <= irq_oe_d;
    end
  end

endmodule

/* shbp_port_unused_guard.sv */
// no logic: the host bus port keeps all of its logic in shbp_port.sv

/* shbp_port_monitor.sv */
// checker for the host bus port pins
module shbp_port_monitor (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        sys_rst,
  // host pins
  input wire logic                        chip_select_low,
  input wire logic                        read_strobe_low,
  input wire logic                        host_data_oe,
  // internal paths
  input wire logic                        csr_wr,
  input wire logic                        csr_rd,
  input wire logic                        tx_push,
  input wire logic                        rx_pop,
  input wire logic                        wake_request,
  input wire logic                        reduced_power,
  // interrupt line
  input wire logic                        irq_out,
  input wire logic                        irq_oe,
  input wire logic                        irq_push_pull,
  input wire logic                        irq_active_high,
  input wire logic [shbp_pkg::HOLD_W-1:0] irq_holdoff
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [3:0]  idle_q; // cycles since chip select pin was low
  logic [11:0] gap_q;  // cycles the line has been inactive
  // line asserted in either buffer mode
  wire irq_act = irq_push_pull ? (irq_oe && irq_out == irq_active_high) : irq_oe;
  // count cycles without chip select
  always_ff @(posedge clk) begin
    if (sys_rst || !chip_select_low) idle_q <= 4'h0;
    else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
  end
  // count inactive interrupt cycles, saturating
  always_ff @(posedge clk) begin
    if (sys_rst) gap_q <= 12'hfff;
    else if (irq_act) gap_q <= 12'h000;
    else if (gap_q != 12'hfff) gap_q <= gap_q + 12'h001;
  end
  AST_OE_RELEASE: assert property ((chip_select_low || read_strobe_low)[*5] |-> !host_data_oe)
    else $error("data bus driven outside a read");
  AST_OE_READ: assert property ((!chip_select_low && !read_strobe_low)[*8] |-> host_data_oe)
    else $error("read not answered");
  AST_ACCESS_CS: assert property ((csr_wr || csr_rd || tx_push || rx_pop) |-> idle_q < 4'hc)
    else $error("internal access without chip select");
  AST_WAKE_QUAL: assert property (wake_request |-> $past(reduced_power) && idle_q < 4'h4)
    else $error("wake without qualified write");
  AST_WORD_ONCE: assert property ((tx_push || csr_wr) |=> !(tx_push || csr_wr)[*8])
    else $error("word completed twice");
  AST_CSR_RD_ONCE: assert property (csr_rd |=> !csr_rd[*4])
    else $error("register read repeated");
  AST_IRQ_OD: assert property (!irq_push_pull && !$past(irq_push_pull) |-> !irq_out)
    else $error("open-drain line driven high");
  AST_IRQ_PP: assert property ($past(irq_push_pull) && !$past(sys_rst) |-> irq_oe)
    else $error("push-pull line not driven");
  AST_IRQ_HOLDOFF: assert property ($rose(irq_act) |-> gap_q >= {4'h0, irq_holdoff} * 12'h00a)
    else $error("interrupt reasserted inside hold-off");
  COV_CSR_WR: cover property (csr_wr);
  COV_TX: cover property (tx_push);
  COV_RX: cover property (rx_pop);
  COV_WAKE: cover property (wake_request);
endmodule
bind shbp_port shbp_port_monitor shbp_port_monitor_inst (.clk, .sys_rst, .chip_select_low,
  .read_strobe_low, .host_data_oe, .csr_wr, .csr_rd, .tx_push, .rx_pop, .wake_request,
  .reduced_power, .irq_out, .irq_oe, .irq_push_pull, .irq_active_high, .irq_holdoff);

/* shbp_host_model.sv */
// host cpu model driving the sram-like pins
module shbp_host_model (
  // clock
  input  wire logic        clk,
  // device side of the data bus
  input  wire logic [15:0] dev_dout,
  input  wire logic        dev_oe,
  // host pins
  output logic      [15:0] bus,
  output logic      [6:0]  addr,
  output logic             read_strobe_low,
  output logic             write_strobe_low,
  output logic             chip_select_low,
  output logic             fsel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] val = 16'h0000; // last value the host drove
  logic        drv = 1'b0;     // host owns the bus
  initial begin
    addr = 7'h00;
    read_strobe_low = 1'b1;
    write_strobe_low = 1'b1;
    chip_select_low = 1'b1;
    fsel = 1'b0;
  end
  // resolved wire; a released bus shows the inverted last value
  assign bus = dev_oe ? dev_dout : (drv ? val : ~val);
  // fifo select level, changed off the clock edge by the caller
  task automatic sel(input logic f);
    fsel = f;
  endtask
  // wait edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one write cycle, data held three cycles past the strobe
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic c);
    cyc(1);
    addr = a;
    val = d;
    drv = 1'b1;
    chip_select_low = c;
    write_strobe_low = 1'b0;
    cyc(4);
    write_strobe_low = 1'b1;
    chip_select_low = 1'b1;
    cyc(3);
    drv = 1'b0;
    cyc(6);
  endtask
  // one read cycle, data taken at the edge that shows the enable
  task automatic rd(input logic [6:0] a, input logic c, output logic [15:0] d, output bit ok);
    cyc(1);
    addr = a;
    ok = 1'b0;
    d = 16'h0000;
    chip_select_low = c;
    read_strobe_low = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = (dev_oe === 1'b1);
      d = dev_dout;
    end
    #1 read_strobe_low = 1'b1;
    chip_select_low = 1'b1;
    cyc(6);
  endtask
endmodule

/* tb.sv */
// self-checking bench for the host bus port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, big_endian, reduced_power, irq_active_high, irq_push_pull;
  logic [31:0] csr_rdata, rx_data, csr_wdata, tx_data, cw_d, tx_d;
  logic [15:0] host_data_out, bus;
  logic [7:0]  irq_sources, irq_enable, irq_holdoff;
  logic [6:0]  host_addr;
  logic [5:0]  csr_addr, cw_a;
  logic [31:0] csr_bank [64]; // register bank behind the internal register bus
  logic        host_data_oe, read_strobe_low, write_strobe_low, chip_select_low, fifo_select;
  logic        wake_request, csr_wr, csr_rd, tx_push, rx_pop, irq_out, irq_oe;
  int          err_count = 0, samples_checked = 0, n_cw = 0, n_cr = 0, n_tx = 0, n_rx = 0, n_wk = 0;
  shbp_port shbp_port_inst (.clk, .sys_rst, .host_data_in(bus), .host_data_out, .host_data_oe,
    .host_addr, .read_strobe_low, .write_strobe_low, .chip_select_low, .fifo_select, .big_endian,
    .reduced_power, .wake_request, .csr_addr, .csr_wdata, .csr_wr, .csr_rd, .csr_rdata, .tx_data,
    .tx_push, .rx_data, .rx_pop, .irq_sources, .irq_enable, .irq_active_high, .irq_push_pull,
    .irq_holdoff, .irq_out, .irq_oe);
  shbp_host_model shbp_host_model_inst (.clk, .dev_dout(host_data_out), .dev_oe(host_data_oe),
    .bus, .addr(host_addr), .read_strobe_low, .write_strobe_low, .chip_select_low,
    .fsel(fifo_select));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // record internal events
  always @(posedge clk) begin
    if (csr_wr === 1'b1) begin n_cw++; cw_a = csr_addr; cw_d = csr_wdata; end
    if (tx_push === 1'b1) begin n_tx++; tx_d = tx_data; end
    if (csr_rd === 1'b1) n_cr++;
    if (rx_pop === 1'b1) n_rx++;
    if (wake_request === 1'b1) n_wk++;
  end
  // register bank and receive fifo head behind the internal paths
  always @(posedge clk) begin
    if (csr_wr === 1'b1) csr_bank[csr_addr] <= csr_wdata;
    if (rx_pop === 1'b1) rx_data <= rx_data + 32'h0000_0001;
  end
  assign csr_rdata = csr_bank[csr_addr];
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // register path, both byte orders
  task automatic t_csr(input logic be);
    logic [15:0] d;
    bit          ok;
    int          w;
    big_endian = be;
    w = n_cw;
    shbp_host_model_inst.wr(7'h20, 16'h1234, 1'b0);
    chk("csr half", w, n_cw);
    shbp_host_model_inst.wr(7'h21, 16'h5678, 1'b0);
    chk("csr writes", w + 1, n_cw);
    chk("csr addr", 32'h0000_0010, {26'h0, cw_a});
    chk("csr wdata", be ? 32'h3412_7856 : 32'h5678_1234, cw_d);
    w = n_cr;
    shbp_host_model_inst.rd(7'h20, 1'b0, d, ok);
    chk("csr rd lo", 32'h0000_1234, {16'h0, d});
    shbp_host_model_inst.rd(7'h21, 1'b0, d, ok);
    chk("csr rd hi", 32'h0000_5678, {16'h0, d});
    chk("csr reads", w + 1, n_cr);
  endtask
  // fifo paths by region and by fifo select
  task automatic t_fifo(input logic fs);
    logic [15:0] d;
    bit          ok;
    int          t, r, c;
    logic [31:0] e;
    t = n_tx;
    r = n_rx;
    e = 32'h1357_9bdf + 32'(r);
    c = n_cw + n_cr;
    shbp_host_model_inst.sel(fs);
    shbp_host_model_inst.wr(fs ? 7'h7e : 7'h10, 16'hbeef, 1'b0);
    shbp_host_model_inst.wr(fs ? 7'h7f : 7'h11, 16'hcafe, 1'b0);
    chk("tx pushes", t + 1, n_tx);
    chk("tx data", 32'hcafe_beef, tx_d);
    shbp_host_model_inst.rd(fs ? 7'h5c : 7'h00, 1'b0, d, ok);
    chk("rx lo", {16'h0, e[15:0]}, {16'h0, d});
    shbp_host_model_inst.rd(fs ? 7'h5d : 7'h01, 1'b0, d, ok);
    chk("rx hi", {16'h0, e[31:16]}, {16'h0, d});
    chk("rx pops", r + 1, n_rx);
    chk("no csr", c, n_cw + n_cr);
    shbp_host_model_inst.sel(1'b0);
  endtask
  // strobes without chip select, then wake
  task automatic t_cs_wake;
    logic [15:0] d;
    bit          ok;
    int          c;
    c = n_cw + n_cr + n_tx + n_rx;
    shbp_host_model_inst.wr(7'h20, 16'h0001, 1'b1);
    shbp_host_model_inst.wr(7'h21, 16'h0002, 1'b1);
    shbp_host_model_inst.rd(7'h00, 1'b1, d, ok);
    chk("no cs access", c, n_cw + n_cr + n_tx + n_rx);
    chk("no cs drive", 0, ok);
    reduced_power = 1'b1;
    c = n_wk;
    shbp_host_model_inst.wr(7'h20, 16'h0003, 1'b1);
    chk("wake no cs", c, n_wk);
    shbp_host_model_inst.wr(7'h20, 16'h0003, 1'b0);
    chk("wake", c + 1, n_wk);
    reduced_power = 1'b0;
  endtask
  // interrupt line, hold-off, then the given buffer mode and polarity
  task automatic t_irq(input logic pp, input logic ah);
    irq_holdoff = 8'h02;
    irq_sources = 8'h01;
    irq_enable = 8'h01;
    shbp_host_model_inst.cyc(3);
    chk("irq on", 2'b11, {irq_oe, irq_out});
    irq_enable = 8'h00;
    shbp_host_model_inst.cyc(3);
    chk("irq masked", 2'b10, {irq_oe, irq_out});
    irq_enable = 8'h01;
    shbp_host_model_inst.cyc(12);
    chk("irq holdoff", 2'b10, {irq_oe, irq_out});
    shbp_host_model_inst.cyc(12);
    chk("irq again", 2'b11, {irq_oe, irq_out});
    sys_rst = 1'b1;
    irq_push_pull = pp;
    irq_active_high = ah;
    shbp_host_model_inst.cyc(10);
    sys_rst = 1'b0;
    shbp_host_model_inst.cyc(4);
    chk("od on", 2'b10, {irq_oe, irq_out});
    irq_enable = 8'h00;
    shbp_host_model_inst.cyc(3);
    chk("od off", 2'b00, {irq_oe, irq_out});
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #60000;
    err_count++;
    end_sim;
  end
  // main sequence
  initial begin
    {sys_rst, irq_active_high, irq_push_pull} = 3'h7;
    {big_endian, reduced_power, irq_sources, irq_enable, irq_holdoff} = 26'h0;
    rx_data = 32'h1357_9bdf;
    shbp_host_model_inst.cyc(10);
    sys_rst = 1'b0;
    shbp_host_model_inst.cyc(3);
    t_csr(1'b0);
    t_csr(1'b1);
    t_fifo(1'b0);
    t_fifo(1'b1);
    t_cs_wake;
    t_irq(1'b0, 1'b0);
    end_sim;
  end
endmodule
